// File: hw/cpu_addr_flags_consts.vh
`ifndef CPU_ADDR_FLAGS_CONSTS_VH
`define CPU_ADDR_FLAGS_CONSTS_VH
// data addressing modes
`define AMODE_DIRECT 3'h0
`define AMODE_INDEX 3'h1
`define AMODE_IMM_OFS 3'h2
`define AMODE_REG_OFS 3'h3
`define AMODE_POST 3'h4
`define AMODE_PRE 3'h5
// alu operation classes
`define ALU_MOVE 4'h0
`define ALU_ADD 4'h1
`define ALU_SUB 4'h2
`define ALU_CMP 4'h3
`define ALU_AND 4'h4
`define ALU_OR 4'h5
`define ALU_XOR 4'h6
`define ALU_SHL 4'h7
`define ALU_SHR 4'h8
`define ALU_SHRA 4'h9
// branch conditions
`define BR_CS 4'h0
`define BR_CC 4'h1
`define BR_VS 4'h2
`define BR_VC 4'h3
`define BR_ZS 4'h4
`define BR_ZC 4'h5
`define BR_EV 4'h6
`define BR_EQ 4'h7
`define BR_NE 4'h8
`define BR_GT 4'h9
`define BR_GE 4'hA
`define BR_LT 4'hB
`define BR_LE 4'hC
`define BR_ALWAYS 4'hD
// program counter control
`define PC_NEXT 3'h0
`define PC_JUMP 3'h1
`define PC_BRANCH 3'h2
`define PC_CALL 3'h3
`define PC_SOFTWARE_CALL_OP 3'h4
`define PC_RET 3'h5
`define PC_JUMP_INDEX 3'h6
`define PC_RESET_VAL 16'h0000
`define STACK_DEPTH 4
`endif

// File: hw/addr_gen.v
`include "cpu_addr_flags_consts.vh"
`default_nettype none
// combinational data address former; index write-back computed here too
module addr_gen
(
    input wire [2:0] addrMode,
    input wire [15:0] indexValue,
    input wire [7:0] addrField,
    input wire [7:0] offsetReg,
    output reg [15:0] dataAddr,
    output reg [15:0] indexNext,
    output reg indexUpdate
);
    wire [6:0] step = addrField[6:0];

    always @*
    begin
        dataAddr = indexValue;
        indexNext = indexValue;
        indexUpdate = 1'b0;
        case (addrMode)
            `AMODE_DIRECT: dataAddr = {8'h00, addrField};
            `AMODE_INDEX: dataAddr = indexValue;
            `AMODE_IMM_OFS: dataAddr = indexValue + {8'h00, addrField};
            `AMODE_REG_OFS: dataAddr = indexValue + {8'h00, offsetReg};
            `AMODE_POST:
            begin
                dataAddr = indexValue;
                indexNext = indexValue + {9'h000, step};
                indexUpdate = 1'b1;
            end
            `AMODE_PRE:
            begin
                indexNext = indexValue - {9'h000, step};
                dataAddr = indexNext;
                indexUpdate = 1'b1;
            end
            default: dataAddr = indexValue;
        endcase
    end
endmodule // addr_gen
`default_nettype wire

// File: hw/branch_eval.v
`include "cpu_addr_flags_consts.vh"
`default_nettype none
// decides whether a branch is taken from the stored flags
module branch_eval
(
    input wire [3:0] cond,
    input wire carryFlag,
    input wire overflowFlag,
    input wire zeroFlag,
    input wire [1:0] eventFlags,
    output reg taken
);
    // after compare: carry low means d > s, zero means equal
    wire cmpGt = ~carryFlag & ~zeroFlag;

    always @*
    begin
        case (cond)
            `BR_CS: taken = carryFlag;
            `BR_CC: taken = ~carryFlag;
            `BR_VS: taken = overflowFlag;
            `BR_VC: taken = ~overflowFlag;
            `BR_ZS: taken = zeroFlag;
            `BR_ZC: taken = ~zeroFlag;
            `BR_EV: taken = |eventFlags;
            `BR_EQ: taken = zeroFlag;
            `BR_NE: taken = ~zeroFlag;
            `BR_GT: taken = cmpGt;
            `BR_GE: taken = cmpGt | zeroFlag;
            `BR_LT: taken = ~cmpGt & ~zeroFlag;
            `BR_LE: taken = ~cmpGt;
            `BR_ALWAYS: taken = 1'b1;
            default: taken = 1'b0;
        endcase
    end
endmodule // branch_eval
`default_nettype wire

// File: hw/cpu_addr_flags_branch.v
`include "cpu_addr_flags_consts.vh"
`default_nettype none
module cpu_addr_flags_branch
#(
    parameter STACK_DEPTH = `STACK_DEPTH
)
(
    input wire clk_sys,
    input wire reset_n,
    // data memory access, one instruction per enabled cycle
    input wire instrValid,
    input wire memAccess,
    input wire [2:0] addrMode,
    input wire [1:0] indexSel,
    input wire [7:0] addrField,
    // result write into an index byte, applied after any update
    input wire resultToIndex,
    input wire [1:0] resultIndexSel,
    input wire resultHighByte,
    // program index byte writes
    input wire progIndexWrLow,
    input wire progIndexWrHigh,
    input wire [7:0] progIndexWrData,
    // alu
    input wire aluValid,
    input wire [3:0] aluOp,
    input wire [7:0] aluDest,
    input wire [7:0] aluSrc,
    input wire aluCarryIn,
    input wire [7:0] offsetRegThree,
    input wire [1:0] eventFlags,
    // program flow
    input wire [2:0] pcCtrl,
    input wire [3:0] branchCond,
    input wire [15:0] jumpTarget,
    input wire intRequest,
    input wire [15:0] intVector,
    output reg [15:0] progAddr,
    output reg [15:0] dataMemAddrBus,
    output reg dataMemAccess,
    output reg [15:0] dataIndexZero,
    output reg [15:0] dataIndexOne,
    output reg [15:0] dataIndexTwo,
    output reg [15:0] dataIndexThree,
    output reg [15:0] programIndex,
    output reg [7:0] accum,
    output reg carryFlag,
    output reg overflowFlag,
    output reg zeroFlag,
    output reg branchTaken,
    output wire intBlocked,
    output wire stackFull,
    output reg stackUnderflow
);
    localparam SP_W = 4;

    reg [15:0] indexSelVal;
    wire [15:0] agAddr;
    wire [15:0] agIndexNext;
    wire agIndexUpdate;
    wire condTaken;
    reg [15:0] pcStack [0:STACK_DEPTH-1];
    reg [SP_W-1:0] stackCount;
    reg [7:0] aluRes;
    reg aluC;
    reg aluV;
    reg flagsTouched;
    reg [8:0] wideSum;
    integer i;

    function [15:0] pick_index;
        input [1:0] sel;
        input [15:0] z;
        input [15:0] o;
        input [15:0] t;
        input [15:0] h;
        begin
            if (sel == 2'h0)
                pick_index = z;
            else if (sel == 2'h1)
                pick_index = o;
            else if (sel == 2'h2)
                pick_index = t;
            else
                pick_index = h;
        end
    endfunction

    // merges a new byte into one half of an index value
    function [15:0] put_byte;
        input [15:0] base;
        input hi;
        input [7:0] b;
        begin
            if (hi)
                put_byte = {b, base[7:0]};
            else
                put_byte = {base[15:8], b};
        end
    endfunction

    always @*
    begin
        indexSelVal = pick_index(indexSel, dataIndexZero, dataIndexOne,
            dataIndexTwo, dataIndexThree);
    end

    addr_gen u_addr_gen
    (
        .addrMode(addrMode),
        .indexValue(indexSelVal),
        .addrField(addrField),
        .offsetReg(offsetRegThree),
        .dataAddr(agAddr),
        .indexNext(agIndexNext),
        .indexUpdate(agIndexUpdate)
    );

    branch_eval u_branch_eval
    (
        .cond(branchCond),
        .carryFlag(carryFlag),
        .overflowFlag(overflowFlag),
        .zeroFlag(zeroFlag),
        .eventFlags(eventFlags),
        .taken(condTaken)
    );

    assign stackFull = (stackCount == STACK_DEPTH[SP_W-1:0]);
    // no early lift on a same-cycle return: the interrupt would drop that return
    assign intBlocked = stackFull;

    // alu: carry for add is carry-out; for sub carry is borrow; for cmp carry is set when d <= s
    always @*
    begin
        aluRes = 8'h00;
        aluC = carryFlag;
        aluV = overflowFlag;
        flagsTouched = 1'b0;
        wideSum = 9'h000;
        case (aluOp)
            `ALU_MOVE: aluRes = aluSrc;
            `ALU_ADD:
            begin
                wideSum = {1'b0, aluDest} + {1'b0, aluSrc} + {8'h00, aluCarryIn};
                aluRes = wideSum[7:0];
                aluC = wideSum[8];
                aluV = (aluDest[7] == aluSrc[7]) & (aluRes[7] != aluDest[7]);
                flagsTouched = 1'b1;
            end
            `ALU_SUB, `ALU_CMP:
            begin
                wideSum = {1'b0, aluDest} - {1'b0, aluSrc};
                aluRes = wideSum[7:0];
                if (aluOp == `ALU_CMP)
                begin
                    // inverted borrow of s - d: low when d > s
                    aluC = (aluDest <= aluSrc);
                    aluV = (aluDest <= aluSrc) & (aluRes != 8'h00);
                end
                else
                begin
                    aluC = wideSum[8];
                    aluV = (aluDest[7] != aluSrc[7]) & (aluRes[7] != aluDest[7]);
                end
                flagsTouched = 1'b1;
            end
            `ALU_AND: aluRes = aluDest & aluSrc;
            `ALU_OR: aluRes = aluDest | aluSrc;
            `ALU_XOR: aluRes = aluDest ^ aluSrc;
            `ALU_SHL:
            begin
                aluRes = {aluDest[6:0], aluCarryIn};
                aluC = aluDest[7];
                aluV = aluDest[7] ^ aluDest[6];
                flagsTouched = 1'b1;
            end
            `ALU_SHR:
            begin
                aluRes = {aluCarryIn, aluDest[7:1]};
                aluC = aluDest[0];
                aluV = 1'b0;
                flagsTouched = 1'b1;
            end
            `ALU_SHRA:
            begin
                aluRes = {aluDest[7], aluDest[7:1]};
                aluC = aluDest[0];
                aluV = 1'b0;
                flagsTouched = 1'b1;
            end
            default: aluRes = aluSrc;
        endcase
    end

    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            accum <= 8'h00;
            carryFlag <= 1'b0;
            overflowFlag <= 1'b0;
            zeroFlag <= 1'b0;
        end
        else if (aluValid)
        begin
            accum <= aluRes;
            zeroFlag <= (aluRes == 8'h00);
            if (flagsTouched)
            begin
                carryFlag <= aluC;
                overflowFlag <= aluV;
            end
        end
    end

    // index registers: modification first, then result byte on top
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            dataIndexZero <= 16'h0000;
            dataIndexOne <= 16'h0000;
            dataIndexTwo <= 16'h0000;
            dataIndexThree <= 16'h0000;
            dataMemAddrBus <= 16'h0000;
            dataMemAccess <= 1'b0;
        end
        else
        begin
            dataMemAccess <= instrValid & memAccess;
            if (instrValid & memAccess)
            begin
                dataMemAddrBus <= agAddr;
                if (agIndexUpdate)
                begin
                    case (indexSel)
                        2'h0: dataIndexZero <= agIndexNext;
                        2'h1: dataIndexOne <= agIndexNext;
                        2'h2: dataIndexTwo <= agIndexNext;
                        default: dataIndexThree <= agIndexNext;
                    endcase
                end
            end
            if (instrValid & resultToIndex)
            begin
                // later assignment wins, so the result byte overrides the update
                case (resultIndexSel)
                    2'h0: dataIndexZero <= put_byte(
                        (agIndexUpdate & memAccess & indexSel == 2'h0) ? agIndexNext
                        : dataIndexZero, resultHighByte, aluRes);
                    2'h1: dataIndexOne <= put_byte(
                        (agIndexUpdate & memAccess & indexSel == 2'h1) ? agIndexNext
                        : dataIndexOne, resultHighByte, aluRes);
                    2'h2: dataIndexTwo <= put_byte(
                        (agIndexUpdate & memAccess & indexSel == 2'h2) ? agIndexNext
                        : dataIndexTwo, resultHighByte, aluRes);
                    default: dataIndexThree <= put_byte(
                        (agIndexUpdate & memAccess & indexSel == 2'h3) ? agIndexNext
                        : dataIndexThree, resultHighByte, aluRes);
                endcase
            end
        end
    end

    // program counter, hardware stack, program index
    always @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            progAddr <= `PC_RESET_VAL;
            programIndex <= 16'h0000;
            stackCount <= {SP_W{1'b0}};
            stackUnderflow <= 1'b0;
            branchTaken <= 1'b0;
            for (i = 0; i < STACK_DEPTH; i = i + 1)
                pcStack[i] <= 16'h0000;
        end
        else
        begin
            branchTaken <= 1'b0;
            stackUnderflow <= 1'b0;
            if (progIndexWrLow)
                programIndex[7:0] <= progIndexWrData;
            if (progIndexWrHigh)
                programIndex[15:8] <= progIndexWrData;
            if (intRequest & ~intBlocked)
            begin
                // interrupt call pushes the address it interrupts
                pcStack[stackCount[1:0]] <= progAddr;
                stackCount <= stackCount + 1'b1;
                progAddr <= intVector;
            end
            else if (instrValid)
            begin
                case (pcCtrl)
                    `PC_JUMP: progAddr <= jumpTarget;
                    `PC_JUMP_INDEX: progAddr <= programIndex;
                    `PC_BRANCH:
                    begin
                        branchTaken <= condTaken;
                        progAddr <= condTaken ? jumpTarget : progAddr + 16'h0001;
                    end
                    `PC_CALL:
                    begin
                        if (!stackFull)
                        begin
                            pcStack[stackCount[1:0]] <= progAddr + 16'h0001;
                            stackCount <= stackCount + 1'b1;
                        end
                        progAddr <= jumpTarget;
                    end
                    `PC_SOFTWARE_CALL_OP:
                    begin
                        programIndex <= progAddr + 16'h0001;
                        progAddr <= programIndex;
                    end
                    `PC_RET:
                    begin
                        if (stackCount != {SP_W{1'b0}})
                        begin
                            progAddr <= pcStack[stackCount[1:0] - 2'h1];
                            stackCount <= stackCount - 1'b1;
                        end
                        else
                            stackUnderflow <= 1'b1;
                    end
                    default: progAddr <= progAddr + 16'h0001;
                endcase
            end
        end
    end
endmodule // cpu_addr_flags_branch
`default_nettype wire

// File: dv/dm_model.sv
`default_nettype none
// data memory side: logs each access so the bench can see what reached the array
module dm_model
(
    input wire logic clk_sys,
    input wire logic [15:0] addr,
    input wire logic access,
    output logic [15:0] lastAddr,
    output logic [31:0] accessCount
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] count = '0;
    assign accessCount = count;
    always @(posedge clk_sys)
    begin
        if (access)
        begin
            lastAddr <= addr;
            count <= count + 32'h1;
        end
    end
endmodule // dm_model
`default_nettype wire

// File: dv/addr_flags_checker.sv
`include "cpu_addr_flags_consts.vh"
`default_nettype none
module addr_flags_checker
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic instrValid,
    input wire logic memAccess,
    input wire logic [2:0] addrMode,
    input wire logic [1:0] indexSel,
    input wire logic [7:0] addrField,
    input wire logic aluValid,
    input wire logic [3:0] aluOp,
    input wire logic [7:0] aluDest,
    input wire logic [7:0] aluSrc,
    input wire logic [7:0] offsetRegThree,
    input wire logic intRequest,
    input wire logic [15:0] dataMemAddrBus,
    input wire logic [15:0] dataIndexZero,
    input wire logic [15:0] dataIndexOne,
    input wire logic [15:0] dataIndexTwo,
    input wire logic [15:0] dataIndexThree,
    input wire logic [7:0] accum,
    input wire logic carryFlag,
    input wire logic overflowFlag,
    input wire logic zeroFlag,
    input wire logic intBlocked,
    input wire logic stackFull,
    input wire logic [15:0] progAddr
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!reset_n);
    logic [15:0] idx;
    logic memGo, aluGo;
    assign idx = indexSel == 2'h0 ? dataIndexZero : indexSel == 2'h1 ? dataIndexOne :
        indexSel == 2'h2 ? dataIndexTwo : dataIndexThree;
    // an accepted interrupt drops only the pcCtrl action of the same cycle; memory and alu checks skip that cycle
    assign memGo = instrValid && memAccess && !(intRequest && !intBlocked);
    assign aluGo = aluValid && !(intRequest && !intBlocked);
    property p_direct;
        memGo && addrMode == `AMODE_DIRECT |=> dataMemAddrBus == {8'h00, $past(addrField)};
    endproperty
    a_direct: assert property (p_direct) else $error("direct address wrong");
    property p_index;
        memGo && addrMode == `AMODE_INDEX |=> dataMemAddrBus == $past(idx);
    endproperty
    a_index: assert property (p_index) else $error("indexed address wrong");
    property p_imm;
        memGo && addrMode == `AMODE_IMM_OFS |=> dataMemAddrBus == $past(idx + addrField);
    endproperty
    a_imm: assert property (p_imm) else $error("immediate offset address wrong");
    property p_reg;
        memGo && addrMode == `AMODE_REG_OFS |=> dataMemAddrBus == $past(idx + offsetRegThree);
    endproperty
    a_reg: assert property (p_reg) else $error("register offset address wrong");
    property p_post;
        memGo && addrMode == `AMODE_POST |=> dataMemAddrBus == $past(idx);
    endproperty
    a_post: assert property (p_post) else $error("post-modify address wrong");
    property p_pre;
        memGo && addrMode == `AMODE_PRE
            |=> dataMemAddrBus == $past(idx - {9'h000, addrField[6:0]});
    endproperty
    a_pre: assert property (p_pre) else $error("pre-modify address wrong");
    property p_zero;
        aluGo && aluOp != `ALU_CMP |=> zeroFlag == (accum == 8'h00);
    endproperty
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    property p_keep;
        aluGo && aluOp inside {`ALU_MOVE, `ALU_AND, `ALU_OR, `ALU_XOR}
            |=> $stable({carryFlag, overflowFlag});
    endproperty
    a_keep: assert property (p_keep) else $error("carry or overflow changed");
    property p_cmp;
        aluGo && aluOp == `ALU_CMP |=> carryFlag == ($past(aluDest) <= $past(aluSrc))
            && overflowFlag == (carryFlag && !zeroFlag);
    endproperty
    a_cmp: assert property (p_cmp) else $error("compare flags wrong");
    property p_move;
        aluGo && aluOp == `ALU_MOVE |=> accum == $past(aluSrc);
    endproperty
    a_move: assert property (p_move) else $error("accumulator not loaded");
    property p_full;
        stackFull && intRequest && !instrValid |-> intBlocked ##1 $stable(progAddr);
    endproperty
    a_full: assert property (p_full) else $error("interrupt open with full stack");
endmodule // addr_flags_checker
bind cpu_addr_flags_branch addr_flags_checker chk (.*);
`default_nettype wire

// File: dv/test_cpu_addr_flags_branch.sv
`include "cpu_addr_flags_consts.vh"
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module test_cpu_addr_flags_branch;
    timeunit 1ns;
    timeprecision 100ps;
    int n_errors = 0, n_compared = 0;
    logic clk_sys = '0, reset_n = '0, instrValid = '0, memAccess = '0, resultToIndex = '0;
    logic resultHighByte = '0, progIndexWrLow = '0, progIndexWrHigh = '0, aluValid = '0;
    logic aluCarryIn = '0, intRequest = '0, tk, ma, uf;
    logic [31:0] nAccess;
    logic [1:0] indexSel = '0, resultIndexSel = '0, eventFlags = '0;
    logic [2:0] addrMode = '0, pcCtrl = '0;
    logic [3:0] aluOp = '0, branchCond = '0;
    logic [7:0] addrField = '0, progIndexWrData = '0, aluDest = '0, aluSrc = '0;
    logic [7:0] offsetRegThree = 8'hFF, accum, d, s;
    logic [7:0] dl [3] = '{8'h80, 8'h03, 8'hFF};
    logic [7:0] sl [3] = '{8'h7F, 8'h05, 8'hFF};
    logic [15:0] jumpTarget = '0, intVector = '0, progAddr, dataMemAddrBus, programIndex;
    logic [15:0] dataIndexZero, dataIndexOne, dataIndexTwo, dataIndexThree, lastAddr;
    logic dataMemAccess, carryFlag, overflowFlag, zeroFlag, branchTaken, intBlocked;
    logic stackFull, stackUnderflow;
    cpu_addr_flags_branch #(.STACK_DEPTH(4)) dut (.*);
    dm_model mem_side (.clk_sys(clk_sys), .addr(dataMemAddrBus), .access(dataMemAccess),
        .lastAddr(lastAddr), .accessCount(nAccess));
    always #2.5 clk_sys = ~clk_sys;
    // pulses are caught before the idle cycle; requests drop only after that
    task automatic cyc();
        @(posedge clk_sys);
        @(negedge clk_sys);
        tk = branchTaken;
        ma = dataMemAccess;
        uf = stackUnderflow;
        instrValid = 1'h0;
        memAccess = 1'h0;
        aluValid = 1'h0;
        resultToIndex = 1'h0;
        progIndexWrLow = 1'h0;
        progIndexWrHigh = 1'h0;
        intRequest = 1'h0;
        pcCtrl = `PC_NEXT;
        @(negedge clk_sys);
    endtask
    task automatic alu(input logic [3:0] op, input logic [7:0] dv, sv);
        instrValid = 1'h1;
        aluValid = 1'h1;
        aluOp = op;
        aluDest = dv;
        aluSrc = sv;
        cyc();
    endtask
    task automatic setIdx(input logic [1:0] sel, input logic [15:0] v);
        for (int h = 0; h < 2; h++)
        begin
            resultToIndex = 1'h1;
            resultIndexSel = sel;
            resultHighByte = h[0];
            alu(`ALU_MOVE, 8'h00, h[0] ? v[15:8] : v[7:0]);
        end
    endtask
    task automatic mem(input logic [2:0] m, input logic [1:0] sel, input logic [7:0] f,
        input logic [15:0] exp);
        instrValid = 1'h1;
        memAccess = 1'h1;
        addrMode = m;
        indexSel = sel;
        addrField = f;
        cyc();
        `CHK({ma, dataMemAddrBus, lastAddr}, {1'h1, exp, exp})
    endtask
    task automatic pc(input logic [2:0] c);
        instrValid = 1'h1;
        pcCtrl = c;
        cyc();
    endtask
    task automatic br(input logic [3:0] c, input logic exp);
        branchCond = c;
        pc(`PC_BRANCH);
        `CHK(tk, exp)
    endtask
    task automatic flags(input logic c, v, z);
        `CHK({carryFlag, overflowFlag, zeroFlag}, {c, v, z})
    endtask
    task automatic results();
        $display("compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        repeat (2000) @(posedge clk_sys);
        n_errors++;
        results();
    end
    initial
    begin
        repeat (10) @(negedge clk_sys);
        reset_n = 1'h1;
        `CHK({progAddr, programIndex, dataIndexTwo, stackFull}, 49'h0)
        setIdx(2'h0, 16'hFFF0);
        setIdx(2'h1, 16'h1234);
        `CHK({dataIndexZero, dataIndexOne}, 32'hFFF01234)
        mem(`AMODE_DIRECT, 2'h0, 8'hA5, 16'h00A5);
        mem(`AMODE_INDEX, 2'h1, 8'h00, 16'h1234);
        mem(`AMODE_IMM_OFS, 2'h0, 8'h20, 16'h0010);
        mem(`AMODE_REG_OFS, 2'h1, 8'h00, 16'h1333);
        mem(`AMODE_POST, 2'h1, 8'hFF, 16'h1234);
        `CHK(dataIndexOne, 16'h12B3)
        mem(`AMODE_PRE, 2'h0, 8'h7F, 16'hFF71);
        `CHK(dataIndexZero, 16'hFF71)
        mem(`AMODE_PRE, 2'h2, 8'h01, 16'hFFFF);
        `CHK(dataIndexTwo, 16'hFFFF)
        mem(`AMODE_POST, 2'h3, 8'h05, 16'h0000);
        `CHK(dataIndexThree, 16'h0005)
        // index is both address source and destination of a move
        resultToIndex = 1'h1;
        resultIndexSel = 2'h1;
        resultHighByte = 1'h1;
        aluValid = 1'h1;
        aluOp = `ALU_MOVE;
        aluSrc = 8'hAB;
        mem(`AMODE_POST, 2'h1, 8'h01, 16'h12B3);
        `CHK({dataIndexOne, accum}, 24'hABB4AB)
        alu(`ALU_ADD, 8'hFF, 8'h01);
        flags(1'h1, 1'h0, 1'h1);
        `CHK(accum, 8'h00)
        alu(`ALU_ADD, 8'h7F, 8'h01);
        flags(1'h0, 1'h1, 1'h0);
        alu(`ALU_AND, 8'h00, 8'hFF);
        flags(1'h0, 1'h1, 1'h1);
        alu(`ALU_XOR, 8'hF0, 8'hFF);
        `CHK({carryFlag, overflowFlag, zeroFlag, accum}, 11'h20F)
        alu(`ALU_OR, 8'h0F, 8'h30);
        `CHK(accum, 8'h3F)
        alu(`ALU_SUB, 8'h00, 8'h01);
        flags(1'h1, 1'h0, 1'h0);
        alu(`ALU_SUB, 8'h80, 8'h01);
        flags(1'h0, 1'h1, 1'h0);
        aluCarryIn = 1'h1;
        alu(`ALU_ADD, 8'h01, 8'h01);
        `CHK({carryFlag, overflowFlag, accum}, 10'h003)
        aluCarryIn = 1'h0;
        alu(`ALU_SHL, 8'h81, 8'h81);
        `CHK({carryFlag, accum}, 9'h102)
        alu(`ALU_SHR, 8'h02, 8'h02);
        `CHK({carryFlag, accum}, 9'h001)
        alu(`ALU_SHRA, 8'h81, 8'h81);
        `CHK({carryFlag, accum}, 9'h1C0)
        for (int i = 0; i < 3; i++)
        begin
            d = dl[i];
            s = sl[i];
            alu(`ALU_CMP, d, s);
            flags(d <= s, d < s, d == s);
            br(`BR_EQ, d == s);
            br(`BR_NE, d != s);
            br(`BR_GT, d > s);
            br(`BR_GE, d >= s);
            br(`BR_LT, d < s);
            br(`BR_LE, d <= s);
            br(`BR_CS, d <= s);
            br(`BR_CC, d > s);
            br(`BR_VS, d < s);
            br(`BR_VC, d >= s);
            br(`BR_ZS, d == s);
            br(`BR_ZC, d != s);
        end
        for (int e = 0; e < 4; e++)
        begin
            eventFlags = e[1:0];
            br(`BR_EV, e != 0);
        end
        progIndexWrLow = 1'h1;
        progIndexWrData = 8'h21;
        pc(`PC_NEXT);
        progIndexWrHigh = 1'h1;
        progIndexWrData = 8'h43;
        pc(`PC_NEXT);
        `CHK(programIndex, 16'h4321)
        pc(`PC_JUMP_INDEX);
        `CHK(progAddr, 16'h4321)
        jumpTarget = 16'h0200;
        pc(`PC_CALL);
        `CHK(progAddr, 16'h0200)
        pc(`PC_RET);
        `CHK(progAddr, 16'h4322)
        pc(`PC_RET);
        `CHK(uf, 1'h1)
        jumpTarget = 16'hBEEF;
        pc(`PC_JUMP);
        `CHK(progAddr, 16'hBEEF)
        pc(`PC_SOFTWARE_CALL_OP);
        `CHK({programIndex, progAddr}, 32'hBEF04321)
        for (int k = 0; k < 4; k++)
        begin
            `CHK(intBlocked, 1'h0)
            intRequest = 1'h1;
            intVector = 16'h0100 + 16'(k);
            cyc();
            `CHK(progAddr, intVector)
        end
        `CHK({stackFull, intBlocked}, 2'h3)
        intRequest = 1'h1;
        intVector = 16'h0F00;
        cyc();
        `CHK(progAddr, 16'h0103)
        pc(`PC_RET);
        `CHK({stackFull, intBlocked}, 2'h0)
        `CHK(progAddr, 16'h0102)
        intRequest = 1'h1;
        intVector = 16'h0F00;
        cyc();
        `CHK(progAddr, 16'h0F00)
        `CHK(nAccess, 32'h00000009)
        results();
    end
endmodule // test_cpu_addr_flags_branch
`default_nettype wire
